// [src/clkwrap_pkg.sv]
// Shared constants and types for the multirate clock enable wrapper
package clkwrap_pkg;

   // System clock and synthesis-unit lock timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int LOCK_TIME_NS  = 1000;
   localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Counter width, reset value and saturation limit
   localparam int                PERIOD_W    = 16;
   localparam logic [15:0]       COUNT_RESET = 16'h0000;
   localparam logic [15:0]       CYC_MAX     = 16'hFFFF;

   // Synthesis-unit capacity and output slots, fastest rate first
   localparam int SLOTS_FULL      = 3;
   localparam int SLOTS_SMALL     = 2;
   localparam int SYNTH_OUTS      = 4;
   localparam int SLOT_UNIT       = 0;
   localparam int SLOT_DOUBLED    = 1;
   localparam int SLOT_DIVIDED    = 2;
   localparam int SLOT_FRACTIONAL = 3;

   // Clocking configurations
   typedef enum logic [2:0] {
      MODE_ENABLES = 3'h1,
      MODE_HYBRID  = 3'h2,
      MODE_EXPOSED = 3'h4
   } mode_type;

   // Synthesis-unit lock sequence
   typedef enum logic [2:0] {
      LOCK_HELD = 3'h1,
      LOCK_WAIT = 3'h2,
      LOCK_DONE = 3'h4
   } lock_state_type;

   // Synthesized clock ticks, one bit per output slot
   typedef struct packed {
      logic synth_fractional_out;
      logic synth_divided_out;
      logic synth_doubled_out;
      logic synth_unit_rate_out;
   } synth_clocks_type;

endpackage

// [src/rate_enable_gen.sv]
// Periodic one-cycle enable generator for one sample rate
`timescale 1ns/1ps
module rate_enable_gen #(
   parameter int PW = clkwrap_pkg::PERIOD_W
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   // Control
   input  wire logic          restart,
   input  wire logic          tick,
   input  wire logic [PW-1:0] period,
   // Enable
   output logic               hit,
   output logic               enable
);
   import clkwrap_pkg::*;

   logic [PW-1:0] count;
   logic [PW-1:0] next_count;
   logic          next_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Count ticks, fire on the last one of each period
   always_comb begin
      hit         = !restart && tick && (count == period - 1'b1);
      next_count  = count;
      next_enable = 1'b0;
      if (restart) begin
         next_count = PW'(COUNT_RESET);
      end else if (tick) begin
         next_count  = hit ? PW'(COUNT_RESET) : count + 1'b1;
         next_enable = hit;
      end
   end

   // Registers
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         count  <= PW'(COUNT_RESET);
         enable <= 1'b0;
      end else begin
         count  <= next_count;
         enable <= next_enable;
      end
   end

endmodule

// [src/multirate_clock_enable_wrapper.sv]
// Multirate clocking wrapper: enables, synthesis-unit hybrid or exposed clocks
//
// What this block does
// - Enables mode: one system clock, one clock enable per distinct rate.
// - Every enable repeats after a whole number of system clock periods.
// - Enable interval equals the rate's sample period divided by the base period.
// - Base period is the greatest common divisor of all sample periods.
// - k base periods of the model take exactly k system clock cycles.
// - Enables scheme is default; hybrid and exposed clocks are selectable options.
// - Hybrid: synthesis unit supplies at most three rates, two on small family.
// - Hybrid: rates beyond capacity come from enables on a synthesized clock.
// - Fastest rates fill unit, doubled, then divided outputs in order; fractional stays low.
// - Lock indication is output; outside logic aligns input data with it.
// - Exposed mode: one clock input per rate, driven mutually synchronous.
// - Internal rate of oversampled logic joins all rates for enable generation.
// - Data crosses between clock domains only through dual-port memories or FIFOs.
`timescale 1ns/1ps
module multirate_clock_enable_wrapper #(
   parameter int          NUM_RATES                 = 3,
   parameter int unsigned SAMPLE_PERIODS[NUM_RATES] = '{2, 3, 4},
   parameter int          OVS_RATE                  = 0,
   parameter int unsigned OVS_FACTOR                = 2,
   parameter bit          SMALL_FAMILY              = 1'b0
) (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   // Configuration
   input  wire clkwrap_pkg::mode_type         clock_mode,
   // Synthesis unit
   input  wire logic                          synth_reset,
   output logic                               synth_locked,
   output clkwrap_pkg::synth_clocks_type      synth_out,
   // Exposed per-rate clocks
   input  wire logic [NUM_RATES:0]            rate_clk_in,
   // Rate enables
   output logic [NUM_RATES:0]                 rate_enable
);
   import clkwrap_pkg::*;

   localparam int NR    = NUM_RATES + 1;
   localparam int SLOTS = SMALL_FAMILY ? SLOTS_SMALL : SLOTS_FULL;
   localparam int USED  = (SLOTS < NR) ? SLOTS : NR;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration helpers

   // Rate list, internal oversampled rate appended last
   function automatic int unsigned period_of(input int i);
      if (i < NUM_RATES) return SAMPLE_PERIODS[i];
      return SAMPLE_PERIODS[OVS_RATE] / OVS_FACTOR;
   endfunction

   function automatic int unsigned gcd2(input int unsigned a, input int unsigned b);
      int unsigned t;
      for (int k = 0; k < 64 && b != 0; k++) begin
         t = a % b;
         a = b;
         b = t;
      end
      return a;
   endfunction

   // Base period over every rate
   function automatic int unsigned base_period();
      int unsigned g;
      g = period_of(0);
      for (int i = 1; i < NR; i++) g = gcd2(g, period_of(i));
      return g;
   endfunction

   // Speed rank, fastest rate is rank 0
   function automatic int rank_of(input int i);
      int r;
      r = 0;
      for (int j = 0; j < NR; j++) begin
         if (period_of(j) < period_of(i) || (period_of(j) == period_of(i) && j < i)) r++;
      end
      return r;
   endfunction

   function automatic int index_of_rank(input int r);
      int idx;
      idx = 0;
      for (int j = 0; j < NR; j++) begin
         if (rank_of(j) == r) idx = j;
      end
      return idx;
   endfunction

   localparam int unsigned BASE     = base_period();
   localparam int          REF_RATE = index_of_rank(USED - 1);
   localparam int          FASTEST  = index_of_rank(0);

   ////////////////////////////////////////////////////////////////////////////
   // Mode register and common restart

   mode_type mode_q;
   mode_type mode_sel;
   mode_type next_mode;
   logic     restart;
   logic     hybrid_live;

   // Illegal mode codes fall back to enables
   always_comb begin
      unique case (clock_mode)
         MODE_ENABLES: mode_sel = MODE_ENABLES;
         MODE_HYBRID:  mode_sel = MODE_HYBRID;
         MODE_EXPOSED: mode_sel = MODE_EXPOSED;
         default:      mode_sel = MODE_ENABLES;
      endcase
      next_mode   = mode_sel;
      hybrid_live = (mode_q == MODE_HYBRID) && synth_locked;
      // All counters restart as one so common multiples coincide
      restart     = (mode_sel != mode_q) || ((mode_q == MODE_HYBRID) && !synth_locked);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) mode_q <= MODE_ENABLES;
      else mode_q <= next_mode;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synthesis-unit lock sequence, restarted by the outside reset

   lock_state_type lock_state;
   lock_state_type next_lock_state;
   logic [15:0]    lock_count;
   logic [15:0]    next_lock_count;

   always_comb begin
      next_lock_state = lock_state;
      next_lock_count = lock_count;
      unique case (lock_state)
         LOCK_HELD: begin
            next_lock_count = COUNT_RESET;
            if (!synth_reset && mode_sel == MODE_HYBRID) next_lock_state = LOCK_WAIT;
         end
         LOCK_WAIT: begin
            if (lock_count == 16'(LOCK_CYCLES - 1)) next_lock_state = LOCK_DONE;
            else next_lock_count = lock_count + 1'b1;
         end
         LOCK_DONE: begin
         end
      endcase
      if (synth_reset || mode_sel != MODE_HYBRID) begin
         next_lock_state = LOCK_HELD;
         next_lock_count = COUNT_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lock_state <= LOCK_HELD;
         lock_count <= COUNT_RESET;
      end else begin
         lock_state <= next_lock_state;
         lock_count <= next_lock_count;
      end
   end

   assign synth_locked = (lock_state == LOCK_DONE);

   ////////////////////////////////////////////////////////////////////////////
   // Per-rate enable generation and exposed clock edges

   logic [15:0] cyc;
   logic [15:0] next_cyc;

   // Cycles since the last common restart, saturating
   always_comb next_cyc = restart ? COUNT_RESET : ((cyc == CYC_MAX) ? cyc : cyc + 1'b1);
   always_ff @(posedge clk_sys) begin
      if (!rst_b) cyc <= COUNT_RESET;
      else cyc <= next_cyc;
   end

   // Checks in this module all run on the system clock
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic [NR-1:0] gen_hit;
   logic [NR-1:0] gen_enable;
   logic [NR-1:0] clk_prev;
   logic [NR-1:0] edge_q;
   logic [NR-1:0] next_edge;

   // Exposed clocks are synchronous strobes here, so no domain is crossed
   always_comb next_edge = rate_clk_in & ~clk_prev;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         clk_prev <= '0;
         edge_q   <= '0;
      end else begin
         clk_prev <= rate_clk_in;
         edge_q   <= next_edge;
      end
   end

   for (genvar i = 0; i < NR; i++) begin : g_rate
      localparam int  P_EN    = period_of(i) / BASE;
      localparam bit  CHAINED = (rank_of(i) >= SLOTS);
      localparam int  P_HY    = CHAINED ? period_of(i) / period_of(REF_RATE) : P_EN;
      logic                tick;
      logic [PERIOD_W-1:0] period;

      // Beyond capacity, count ticks of the slowest synthesized clock
      always_comb begin
         tick   = (mode_q == MODE_HYBRID && CHAINED) ? gen_hit[REF_RATE] : 1'b1;
         period = (mode_q == MODE_HYBRID) ? PERIOD_W'(P_HY) : PERIOD_W'(P_EN);
      end

      rate_enable_gen #(.PW(PERIOD_W)) u_gen (
         .clk_sys (clk_sys),
         .rst_b   (rst_b),
         .restart (restart),
         .tick    (tick),
         .period  (period),
         .hit     (gen_hit[i]),
         .enable  (gen_enable[i])
      );

      // One-cycle pulse per period
      if (P_EN > 1) begin : g_one
         AST_ENABLE_ONE_CYCLE: assert property (mode_q == MODE_ENABLES && rate_enable[i] |=> !rate_enable[i])
            else $error("enable stayed high for more than one cycle");
      end

      // Enable lands on every multiple of its period after restart
      AST_ENABLE_ON_MULTIPLE: assert property (mode_q == MODE_ENABLES && $past(mode_q) == MODE_ENABLES
                                               && cyc != CYC_MAX
                                               |-> rate_enable[i] == (cyc != 16'h0000 && (cyc % P_EN) == 0))
         else $error("enable not on a multiple of its period");

      // Exposed clock rising edge gives an enable one cycle later
      AST_EXPOSED_EDGE: assert property (mode_q == MODE_EXPOSED && $past(mode_q) == MODE_EXPOSED
                                         && rate_clk_in[i] && !clk_prev[i] |=> rate_enable[i])
         else $error("exposed clock edge gave no enable");

      if (CHAINED) begin : g_chain
         AST_CHAINED_ON_REF: assert property (hybrid_live && rate_enable[i] |-> rate_enable[REF_RATE])
            else $error("chained enable without a synthesized tick");
      end
   end

   // Output selection by configuration
   always_comb begin
      unique case (mode_q)
         MODE_ENABLES: rate_enable = gen_enable;
         MODE_HYBRID:  rate_enable = synth_locked ? gen_enable : '0;
         MODE_EXPOSED: rate_enable = edge_q;
         default:      rate_enable = '0;
      endcase
   end

   // Synthesis-unit outputs, fastest rates first
   logic [SYNTH_OUTS-1:0] synth_vec;
   for (genvar s = 0; s < SYNTH_OUTS; s++) begin : g_slot
      if (s < USED) begin : g_used
         assign synth_vec[s] = hybrid_live && gen_enable[index_of_rank(s)];
      end else begin : g_unused
         assign synth_vec[s] = 1'b0;
      end
   end
   assign synth_out = synth_clocks_type'(synth_vec);

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   AST_BASE_DIVIDES: assert property (period_of(0) % BASE == 0 && BASE >= 1)
      else $error("base period does not divide the rates");

   AST_HYBRID_HELD_UNLOCKED: assert property (mode_q == MODE_HYBRID && !synth_locked |-> rate_enable == '0)
      else $error("enable while synthesis unit unlocked");

   AST_LOCK_AFTER_COUNT: assert property (synth_locked |-> lock_count == 16'(LOCK_CYCLES - 1))
      else $error("lock before the lock time elapsed");

   AST_RESET_DROPS_LOCK: assert property (synth_reset |=> !synth_locked)
      else $error("lock held through synthesis-unit reset");

   AST_SLOT_PRIORITY: assert property (hybrid_live |-> synth_out.synth_unit_rate_out == rate_enable[FASTEST])
      else $error("unit-rate output not on the fastest rate");

   AST_NO_SYNTH_OUTSIDE_HYBRID: assert property (mode_q != MODE_HYBRID |-> synth_vec == '0)
      else $error("synthesized clock outside hybrid mode");

   AST_SLOT_LIMIT: assert property (SMALL_FAMILY |-> !synth_out.synth_divided_out && !synth_out.synth_fractional_out)
      else $error("small family used a third synthesis output");

   COV_ALL_COINCIDE: cover property (mode_q == MODE_ENABLES && (&rate_enable));
   COV_HYBRID_LOCK: cover property (mode_q == MODE_HYBRID && $rose(synth_locked));
   COV_CHAIN_FIRE: cover property (hybrid_live && rate_enable[index_of_rank(NR - 1)]);
   COV_EXPOSED_EDGE: cover property (mode_q == MODE_EXPOSED && rate_enable[0]);

endmodule

// [test/far_side_model.sv]
// Far-side model: synthesis-unit reset source and external synchronous clock source
`timescale 1ns/1ps
module far_side_model (
   // Clock
   input  wire logic       clk_sys,
   // Control from the bench
   input  wire logic       cfg_done,
   input  wire logic       reset_req,
   input  wire logic       gen_run,
   input  wire logic [3:0] clk_mask,
   // Toward the wrapper
   output logic            synth_reset,
   output logic [3:0]      rate_clk_in
);
   int half [4] = '{2, 3, 4, 1};
   int cnt [4];

   // Known levels before the first edge
   initial begin
      synth_reset = 1'b1;
      rate_clk_in = 4'h0;
   end

   // Unit held in reset until configuration ends, then only on request
   always @(posedge clk_sys) begin
      synth_reset <= !cfg_done || reset_req;
   end

   // One edge drives every clock, so all stay synchronous; still when stopped
   always @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (!gen_run) begin
            cnt[i]         <= 0;
            rate_clk_in[i] <= 1'b0;
         end else if (cnt[i] == half[i] - 1) begin
            cnt[i]         <= 0;
            rate_clk_in[i] <= ~rate_clk_in[i] & clk_mask[i];
         end else begin
            cnt[i]         <= cnt[i] + 1;
         end
      end
   end
endmodule

// [test/test_multirate_clock_enable_wrapper.sv]
// Testbench for the multirate clock enable wrapper
`timescale 1ns/1ps
module test_multirate_clock_enable_wrapper;
   import clkwrap_pkg::*;
   logic             clk_sys = 1'b0;
   logic             rst_b = 1'b0;
   mode_type         clock_mode = MODE_ENABLES;
   logic             cfg_done = 1'b0;
   logic             reset_req = 1'b0;
   logic             gen_run = 1'b0;
   logic [3:0]       clk_mask = 4'h0;
   logic             synth_reset;
   logic             synth_locked;
   synth_clocks_type synth_out;
   logic [3:0]       rate_clk_in;
   logic [3:0]       rate_enable;
   logic [17:0]      exp_q[$];
   logic [17:0]      note;
   logic [3:0]       cur;
   logic [3:0]       prev;
   logic [3:0]       pend;
   int               n_mismatch = 0;
   int               checked = 0;
   int               waits;
   int               seed = 32'h8A98;

   always #20 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////
   // Design and far side
   multirate_clock_enable_wrapper uut (.clk_sys(clk_sys), .rst_b(rst_b), .clock_mode(clock_mode),
      .synth_reset(synth_reset), .synth_locked(synth_locked), .synth_out(synth_out),
      .rate_clk_in(rate_clk_in), .rate_enable(rate_enable));
   far_side_model far_side (.clk_sys(clk_sys), .cfg_done(cfg_done), .reset_req(reset_req),
      .gen_run(gen_run), .clk_mask(clk_mask), .synth_reset(synth_reset), .rate_clk_in(rate_clk_in));

   ////////////////////////////////////////////////////////////
   // Comparison and verdict
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] expd);
      checked++;
      if (seen !== expd) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, expd, seen);
      end
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Note one expectation, with its mask, for the state after the next edge
   task automatic expect_next(input logic [8:0] mask, input logic [8:0] expd);
      @(posedge clk_sys);
      exp_q.push_back({mask, expd});
   endtask

   // Enables expected k edges after a counter restart; bit 3 is the oversampled rate
   function automatic logic [3:0] en_exp(input int k);
      int per [4] = '{2, 3, 4, 1};
      for (int i = 0; i < 4; i++)
         en_exp[i] = (k >= 1) && (k % per[i] == 0);
   endfunction

   // First is the edge count since restart of the first noted edge
   task automatic run_enables(input int first, input int count);
      for (int k = first; k < first + count; k++)
         expect_next(9'h1FF, {5'h00, en_exp(k)});
   endtask

   // Oldest note is compared as outputs settle
   always @(negedge clk_sys) begin
      if (exp_q.size() > 0) begin
         note = exp_q.pop_front();
         check("outputs", {synth_locked, synth_out, rate_enable} & note[17:9], note[8:0]);
      end
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      run_enables(1, 25);
      // Hybrid: unlocked while the unit is held in reset
      clock_mode <= MODE_HYBRID;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 8; k++)
         expect_next(9'h1FF, 9'h000);
      cfg_done <= 1'b1;
      waits = 0;
      while (synth_locked !== 1'b1 && waits < 100) begin
         expect_next(9'h0FF, 9'h000);
         @(negedge clk_sys);
         waits++;
      end
      check("lock_wait_ok", {8'h00, waits >= LOCK_CYCLES && waits <= LOCK_CYCLES + 4}, 9'h001);
      for (int k = 1; k <= 12; k++)
         expect_next(9'h1F4, {2'b10, k % 3 == 0, k % 2 == 0, 1'b1, 1'b0, k % 3 == 0, 2'b00});
      // Unit reset again: lock and synthesized ticks drop
      reset_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < 4; k++)
         expect_next(9'h1FF, 9'h000);
      reset_req <= 1'b0;
      // Exposed clocks, random subset of rates
      clock_mode <= MODE_EXPOSED;
      repeat (3) @(posedge clk_sys);
      clk_mask <= 4'($random(seed));
      gen_run  <= 1'b1;
      prev = 4'h0;
      pend = 4'h0;
      for (int k = 0; k < 60; k++) begin
         @(posedge clk_sys);
         cur = rate_clk_in;
         pend = cur & ~prev;
         prev = cur;
         exp_q.push_back({9'h1FF, 5'h00, pend});
         if (k == 30)
            clk_mask <= 4'($random(seed));
      end
      // Back to enables: every counter restarts together
      gen_run    <= 1'b0;
      clock_mode <= MODE_ENABLES;
      run_enables(0, 14);
      repeat (3) @(posedge clk_sys);
      end_of_test();
   end

   // Watchdog
   initial begin
      #(600 * CLK_PERIOD_NS);
      n_mismatch++;
      end_of_test();
   end
endmodule
